// ==== inc/fbh_pkg.sv ====
// package: command codes, query addresses and pin timing for the flash bank host
package fbh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // strobe low and high times in ns, rounded up to whole cycles
  localparam int unsigned WR_LOW_NS     = 50;
  localparam int unsigned WR_HIGH_NS    = 50;
  localparam logic [3:0]  WR_LOW_CYC    = 4'((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  WR_HIGH_CYC   = 4'((WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  RD_ACC_CYC    = 4'((75 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned ADDR_W        = 22;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned NUM_BANKS     = 4;
  // unlock and command values
  localparam logic [21:0] UNLOCK_ADDR1  = 22'h000555;
  localparam logic [21:0] UNLOCK_ADDR2  = 22'h0002AA;
  localparam logic [15:0] UNLOCK_DATA1  = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA2  = 16'h0055;
  localparam logic [15:0] CMD_RESET     = 16'h00F0;
  localparam logic [15:0] CMD_AUTOSEL   = 16'h0090;
  localparam logic [15:0] CMD_QUERY     = 16'h0098;
  localparam logic [21:0] QUERY_ADDR    = 22'h000055;
  // query table word addresses and expected values
  localparam logic [7:0]  Q_BURST_A     = 8'h4B;
  localparam logic [7:0]  Q_PAGE_A      = 8'h4C;
  localparam logic [7:0]  Q_ACC_MIN_A   = 8'h4D;
  localparam logic [7:0]  Q_ACC_MAX_A   = 8'h4E;
  localparam logic [7:0]  Q_BOOT_A      = 8'h4F;
  localparam logic [7:0]  Q_PSUSP_A     = 8'h50;
  localparam logic [7:0]  Q_BANKS_A     = 8'h57;
  localparam logic [7:0]  Q_BANK1_A     = 8'h58;
  localparam logic [15:0] Q_BURST_V     = 16'h0000;
  localparam logic [15:0] Q_PAGE_V      = 16'h0000;
  localparam logic [15:0] Q_ACC_MIN_V   = 16'h0085;
  localparam logic [15:0] Q_ACC_MAX_V   = 16'h0095;
  localparam logic [15:0] Q_BOOT_V      = 16'h0001;
  localparam logic [15:0] Q_PSUSP_V     = 16'h0001;
  localparam logic [15:0] Q_BANKS_V     = 16'h0004;
  localparam logic [15:0] Q_SEC_SMALL_V = 16'h0017;
  localparam logic [15:0] Q_SEC_LARGE_V = 16'h0030;
  localparam logic [3:0]  Q_NUM_CHECKS  = 4'hB;

  typedef enum logic [2:0] {
    OP_RESET    = 3'h0,
    OP_AUTOSEL  = 3'h1,
    OP_QUERY    = 3'h2,
    OP_READ     = 3'h3,
    OP_CHECK    = 3'h4
  } fbh_op_t;

  typedef enum logic [1:0] {
    BM_READ     = 2'h0,
    BM_SUSP_RD  = 2'h1,
    BM_AUTOSEL  = 2'h2,
    BM_QUERY    = 2'h3
  } fbh_bmode_t;
endpackage : fbh_pkg

// ==== inc/fbh_cyc_if.sv ====
// interface: one bus cycle request between sequencer and pin cycle engine
`timescale 1ns/100ps
interface fbh_cyc_if;
  logic        req;
  logic        wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fbh_cyc_if

// ==== hdl/fbh_cycle.sv ====
// module: drives one write or read cycle on the flash pins
`timescale 1ns/100ps
module fbh_cycle
  import fbh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  fbh_cyc_if.eng           cyc,
  input  wire logic [15:0] dq_in_s,
  output logic [21:0]      addr_o,
  output logic [15:0]      dq_out_o,
  output logic             dq_oe_o,
  output logic             cs_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);
  typedef enum logic [1:0] {
    CY_IDLE = 2'h0,
    CY_LOW  = 2'h1,
    CY_HIGH = 2'h2
  } fbh_cy_t;

  fbh_cy_t     st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic        wr_r, wr_nxt;
  logic        done_r, done_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    rdat_nxt = rdat_r;
    wr_nxt   = wr_r;
    done_nxt = 1'b0;
    case (st_r)
      CY_IDLE: begin
        if (cyc.req) begin
          // address is loaded on the same clock edge that both strobes fall together
          addr_nxt = cyc.addr;
          dout_nxt = cyc.wdata;
          wr_nxt   = cyc.wr;
          cnt_nxt  = cyc.wr ? WR_LOW_CYC : RD_ACC_CYC;
          st_nxt   = CY_LOW;
        end
      end
      CY_LOW: begin
        if (cnt_r == 4'h1) begin
          // both strobes rise together, data held stable through it
          if (!wr_r) rdat_nxt = dq_in_s;
          cnt_nxt = WR_HIGH_CYC;
          st_nxt  = CY_HIGH;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      CY_HIGH: begin
        if (cnt_r == 4'h1) begin
          done_nxt = 1'b1;
          st_nxt   = CY_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: st_nxt = CY_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= CY_IDLE;
      cnt_r  <= 4'h0;
      addr_r <= 22'h000000;
      dout_r <= 16'h0000;
      rdat_r <= 16'h0000;
      wr_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      rdat_r <= rdat_nxt;
      wr_r   <= wr_nxt;
      done_r <= done_nxt;
    end
  end

  // data stays driven through the high phase for hold time after the rising edge
  assign addr_o    = addr_r;
  assign dq_out_o  = dout_r;
  assign dq_oe_o   = wr_r && (st_r != CY_IDLE);
  assign cs_n_o    = (st_r != CY_LOW);
  assign we_n_o    = !(wr_r && st_r == CY_LOW);
  assign oe_n_o    = !(!wr_r && st_r == CY_LOW);
  assign cyc.done  = done_r;
  assign cyc.rdata = rdat_r;

  property p_wr_low_len;
    @(posedge clk) disable iff (rst)
    $fell(we_n_o) |-> !we_n_o [*2] ##1 we_n_o;
  endproperty
  a_wr_low_len: assert property (p_wr_low_len) else $error("write strobe low time wrong");

  property p_data_hold;
    @(posedge clk) disable iff (rst)
    $rose(we_n_o) |-> dq_oe_o && $stable(dq_out_o) && $stable(addr_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held at strobe rise");
endmodule : fbh_cycle

// ==== hdl/fbh_host.sv ====
// module: host controller issuing command sequences and reads to a multi-bank flash
`timescale 1ns/100ps
module fbh_host
  import fbh_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        CMD_VALID,
  input  wire fbh_pkg::fbh_op_t CMD_OP,
  input  wire logic [21:0] CMD_ADDR,
  output logic             CMD_READY,
  output logic             RSP_VALID,
  output logic [15:0]      RSP_DATA,
  output logic             RSP_ERR,
  input  wire logic [3:0]  BANK_BUSY,
  input  wire logic [3:0]  BANK_SUSP,
  input  wire logic        TIMEOUT_FLAG,
  output logic [7:0]       BANK_MODES,
  output logic [21:0]      F_ADDR,
  input  wire logic [15:0] F_DQ_IN,
  output logic [15:0]      F_DQ_OUT,
  output logic             F_DQ_OE,
  output logic             F_CS_N,
  output logic             F_WE_N,
  output logic             F_OE_N
);
  import fbh_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] dq_m_r, dq_s_r;
  logic [3:0]  busy_m_r, busy_s_r, busy_d_r, susp_m_r, susp_s_r;
  logic        to_m_r, to_s_r;
  always_ff @(posedge SYS_CLK) begin
    dq_m_r   <= F_DQ_IN;
    dq_s_r   <= dq_m_r;
    busy_m_r <= BANK_BUSY;
    busy_s_r <= busy_m_r;
    busy_d_r <= busy_s_r;
    susp_m_r <= BANK_SUSP;
    susp_s_r <= susp_m_r;
    to_m_r   <= TIMEOUT_FLAG;
    to_s_r   <= to_m_r;
  end

  fbh_cyc_if cyc ();

  fbh_cycle u_cycle (
    .clk      (SYS_CLK),
    .rst      (RST),
    .cyc      (cyc.eng),
    .dq_in_s  (dq_s_r),
    .addr_o   (F_ADDR),
    .dq_out_o (F_DQ_OUT),
    .dq_oe_o  (F_DQ_OE),
    .cs_n_o   (F_CS_N),
    .we_n_o   (F_WE_N),
    .oe_n_o   (F_OE_N)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_STEP = 3'h1,
    SQ_WAIT = 3'h2,
    SQ_RESP = 3'h3
  } fbh_sq_t;

  fbh_sq_t     st_r, st_nxt;
  fbh_op_t     op_r, op_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [3:0]  step_r, step_nxt;
  logic [15:0] rsp_r, rsp_nxt;
  logic        err_r, err_nxt;
  logic        rv_r, rv_nxt;
  fbh_bmode_t  mode_r [NUM_BANKS];
  fbh_bmode_t  mode_nxt [NUM_BANKS];
  logic [1:0]  bank;
  logic        busy_other;
  logic        last_step;
  logic [21:0] s_addr;
  logic [15:0] s_data;
  logic        s_wr;
  logic [15:0] q_exp;
  logic [7:0]  q_wa;

  assign bank = addr_r[21:20];

  // expected query words and their word addresses
  always_comb begin
    q_wa  = Q_BURST_A;
    q_exp = Q_BURST_V;
    case (step_r)
      4'h0: begin q_wa = Q_BURST_A;   q_exp = Q_BURST_V;   end
      4'h1: begin q_wa = Q_PAGE_A;    q_exp = Q_PAGE_V;    end
      4'h2: begin q_wa = Q_ACC_MIN_A; q_exp = Q_ACC_MIN_V; end
      4'h3: begin q_wa = Q_ACC_MAX_A; q_exp = Q_ACC_MAX_V; end
      4'h4: begin q_wa = Q_BOOT_A;    q_exp = Q_BOOT_V;    end
      4'h5: begin q_wa = Q_PSUSP_A;   q_exp = Q_PSUSP_V;   end
      4'h6: begin q_wa = Q_BANKS_A;   q_exp = Q_BANKS_V;   end
      4'h7: begin q_wa = Q_BANK1_A;   q_exp = Q_SEC_SMALL_V; end
      4'h8: begin q_wa = Q_BANK1_A + 8'h01; q_exp = Q_SEC_LARGE_V; end
      4'h9: begin q_wa = Q_BANK1_A + 8'h02; q_exp = Q_SEC_LARGE_V; end
      4'hA: begin q_wa = Q_BANK1_A + 8'h03; q_exp = Q_SEC_SMALL_V; end
      default: begin q_wa = Q_BURST_A; q_exp = Q_BURST_V; end
    endcase
  end

  // bus cycle of the current step; word-mode addressing, byte address is twice this
  always_comb begin
    s_wr      = 1'b1;
    s_addr    = addr_r;
    s_data    = CMD_RESET;
    last_step = 1'b1;
    case (op_r)
      OP_RESET: s_data = CMD_RESET;
      OP_AUTOSEL, OP_QUERY: begin
        last_step = (op_r == OP_QUERY) ? 1'b1 : (step_r == 4'h2);
        case (step_r)
          4'h0: begin
            s_addr = (op_r == OP_QUERY) ? QUERY_ADDR : UNLOCK_ADDR1;
            s_data = (op_r == OP_QUERY) ? CMD_QUERY : UNLOCK_DATA1;
          end
          4'h1: begin s_addr = UNLOCK_ADDR2; s_data = UNLOCK_DATA2; end
          // bank address carried with the command selects the bank
          default: begin s_addr = {addr_r[21:20], UNLOCK_ADDR1[19:0]}; s_data = CMD_AUTOSEL; end
        endcase
      end
      // caller supplies bank and sector bits for protection reads
      OP_READ: s_wr = 1'b0;
      OP_CHECK: begin
        s_wr      = 1'b0;
        s_addr    = {14'h0000, q_wa};
        last_step = (step_r == Q_NUM_CHECKS - 4'h1);
      end
      default: s_data = CMD_RESET;
    endcase
  end

  always_comb begin
    busy_other = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (busy_s_r[i] && (2'(i) != CMD_ADDR[21:20])) busy_other = 1'b1;
    end
  end

  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    addr_nxt = addr_r;
    step_nxt = step_r;
    rsp_nxt  = rsp_r;
    err_nxt  = err_r;
    rv_nxt   = 1'b0;
    // between commands a bank follows its pins; a finished job ends in read, or suspend-read if suspended
    for (int i = 0; i < NUM_BANKS; i++) begin
      mode_nxt[i] = mode_r[i];
      if (busy_d_r[i] && !busy_s_r[i]) mode_nxt[i] = susp_s_r[i] ? BM_SUSP_RD : BM_READ;
      else if (susp_s_r[i] && mode_r[i] == BM_READ) mode_nxt[i] = BM_SUSP_RD;
      else if (!susp_s_r[i] && mode_r[i] == BM_SUSP_RD) mode_nxt[i] = BM_READ;
    end
    case (st_r)
      SQ_IDLE: begin
        if (CMD_VALID) begin
          op_nxt   = CMD_OP;
          addr_nxt = CMD_ADDR;
          step_nxt = 4'h0;
          err_nxt  = 1'b0;
          rsp_nxt  = 16'h0000;
          st_nxt   = SQ_STEP;
          // refuse autoselect while any bank runs an embedded job or the bank is already in autoselect
          if ((CMD_OP == OP_AUTOSEL) && (busy_other || busy_s_r[CMD_ADDR[21:20]] ||
              mode_r[CMD_ADDR[21:20]] == BM_AUTOSEL)) begin
            err_nxt = 1'b1;
            st_nxt  = SQ_RESP;
          end
        end
      end
      SQ_STEP: st_nxt = SQ_WAIT;
      SQ_WAIT: begin
        if (cyc.done) begin
          if (!s_wr) begin
            rsp_nxt = cyc.rdata;
            if (op_r == OP_CHECK && cyc.rdata != q_exp) err_nxt = 1'b1;
          end
          if (last_step) begin
            st_nxt = SQ_RESP;
            case (op_r)
              // reset returns each bank not busy to read, or suspend-read if suspended
              OP_RESET: for (int i = 0; i < NUM_BANKS; i++) // busy bank ignores it
                if (!busy_s_r[i]) mode_nxt[i] = susp_s_r[i] ? BM_SUSP_RD : BM_READ;
              OP_AUTOSEL: mode_nxt[bank] = BM_AUTOSEL;
              OP_QUERY: for (int i = 0; i < NUM_BANKS; i++) mode_nxt[i] = BM_QUERY;
              default: rsp_nxt = rsp_nxt;
            endcase
          end else begin
            step_nxt = step_r + 4'h1;
            st_nxt   = SQ_STEP;
          end
        end
      end
      SQ_RESP: begin
        rv_nxt = 1'b1;
        st_nxt = SQ_IDLE;
      end
      default: st_nxt = SQ_IDLE;
    endcase
    // a timeout flag marks every command but reset as failed for as long as the flag stays set
    if (to_s_r && op_r != OP_RESET) err_nxt = err_nxt | (st_r == SQ_WAIT && cyc.done);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r   <= SQ_IDLE;
      op_r   <= OP_RESET;
      addr_r <= 22'h000000;
      step_r <= 4'h0;
      rsp_r  <= 16'h0000;
      err_r  <= 1'b0;
      rv_r   <= 1'b0;
      // device starts in array read with no command
      for (int i = 0; i < NUM_BANKS; i++) mode_r[i] <= BM_READ;
    end else begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      addr_r <= addr_nxt;
      step_r <= step_nxt;
      rsp_r  <= rsp_nxt;
      err_r  <= err_nxt;
      rv_r   <= rv_nxt;
      for (int i = 0; i < NUM_BANKS; i++) mode_r[i] <= mode_nxt[i];
    end
  end

  assign cyc.req   = (st_r == SQ_STEP);
  assign cyc.wr    = s_wr;
  assign cyc.addr  = s_addr;
  assign cyc.wdata = s_data;
  assign CMD_READY = (st_r == SQ_IDLE);
  assign RSP_VALID = rv_r;
  assign RSP_DATA  = rsp_r;
  assign RSP_ERR   = err_r;
  assign BANK_MODES = {mode_r[3], mode_r[2], mode_r[1], mode_r[0]};

  property p_reset_modes;
    @(posedge SYS_CLK) disable iff (RST)
    (st_r == SQ_WAIT && cyc.done && op_r == OP_RESET && !busy_s_r[0]) |=>
      mode_r[0] == (susp_s_r[0] ? BM_SUSP_RD : BM_READ) || $changed(susp_s_r);
  endproperty
  a_reset_modes: assert property (p_reset_modes) else $error("reset mode wrong");

  property p_autosel_refused;
    @(posedge SYS_CLK) disable iff (RST)
    (CMD_READY && CMD_VALID && CMD_OP == OP_AUTOSEL && busy_other) |-> ##2 RSP_VALID && RSP_ERR;
  endproperty
  a_autosel_refused: assert property (p_autosel_refused) else $error("autoselect not refused");

  property p_autosel_cmd;
    @(posedge SYS_CLK) disable iff (RST)
    (cyc.req && op_r == OP_AUTOSEL && step_r == 4'h2) |-> cyc.wdata == CMD_AUTOSEL;
  endproperty
  a_autosel_cmd: assert property (p_autosel_cmd) else $error("autoselect command bad");

  property p_reset_data;
    @(posedge SYS_CLK) disable iff (RST)
    (cyc.req && op_r == OP_RESET) |-> cyc.wr && cyc.wdata == CMD_RESET;
  endproperty
  a_reset_data: assert property (p_reset_data) else $error("reset data bad");
endmodule : fbh_host

// ==== tb/fbh_flash_model.sv ====
// partner model: flash pins, one command decoder shared by all banks, per-bank modes and read data
`timescale 1ns/100ps
module fbh_flash_model
  import fbh_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00A1, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0B2C  // arbitrary value
)(
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  output logic [15:0]      dq_in,
  input  wire logic [3:0]  busy_set,
  input  wire logic [3:0]  susp_set
);
  logic [21:0] lat_a;
  logic [1:0]  mode [4];
  logic [1:0]  ucnt    = 2'h0;
  logic        qm      = 1'b0;
  logic        wr_open = 1'b0;
  logic [15:0] last    = 16'h0000;
  logic [3:0]  pbusy   = 4'h0;

  initial for (int b = 0; b < 4; b++) mode[b] = 2'h0;

  task automatic cmd_wr(input logic [21:0] a, input logic [15:0] d);
    if (|busy_set) return;
    if (d == CMD_RESET) begin
      for (int b = 0; b < 4; b++) mode[b] = {1'b0, susp_set[b]};
      qm = 1'b0;
      ucnt = 2'h0;
    end else if (ucnt == 2'h0 && a[10:0] == 11'h555 && d == UNLOCK_DATA1) begin
      ucnt = 2'h1;
    end else if (ucnt == 2'h1 && a[10:0] == 11'h2AA && d == UNLOCK_DATA2) begin
      ucnt = 2'h2;
    end else if (ucnt == 2'h2 && d == CMD_AUTOSEL) begin
      mode[a[21:20]] = 2'h2;
      ucnt = 2'h0;
    end else if (a[7:0] == 8'h55 && d == CMD_QUERY) begin
      qm = 1'b1;
    end else begin
      ucnt = 2'h0;
    end
  endtask : cmd_wr

  function automatic logic [15:0] rd_val(input logic [21:0] a);
    if (qm) begin
      case (a[7:0])
        Q_ACC_MIN_A:                   return Q_ACC_MIN_V;
        Q_ACC_MAX_A:                   return Q_ACC_MAX_V;
        Q_BOOT_A, Q_PSUSP_A:           return 16'h0001;
        Q_BANKS_A:                     return 16'h0004;
        Q_BANK1_A, 8'h5B:              return 16'h0017;
        8'h59, 8'h5A:                  return 16'h0030;
        default:                       return 16'h0000;
      endcase
    end
    if (mode[a[21:20]] == 2'h2) begin
      return (a[7:0] == 8'h00) ? MAKER_CODE : (a[7:0] == 8'h01) ? PART_CODE :
             (a[7:0] == 8'h02) ? {15'h0000, a[12]} : 16'h0000;
    end
    if (mode[a[21:20]] == 2'h1 && a[19:12] == 8'h00) return 16'h0080;
    return a[15:0] ^ {2'h0, a[21:20], 12'h5A5};
  endfunction : rd_val

  // address at the later falling edge, data at the earlier rising edge
  always @(negedge we_n or negedge cs_n) if (!we_n && !cs_n) begin
    lat_a = addr;
    wr_open = 1'b1;
  end
  always @(posedge we_n or posedge cs_n) if (wr_open) begin
    wr_open = 1'b0;
    cmd_wr(lat_a, dq_out);
  end

  // released bus shows the inverse of the last word, never a stale copy
  always @* begin
    if (!cs_n && !oe_n) begin
      dq_in = rd_val(addr);
      last = dq_in;
    end else begin
      dq_in = ~last;
    end
  end

  always @(susp_set or busy_set) begin
    for (int b = 0; b < 4; b++) begin
      if (pbusy[b] && !busy_set[b] && !susp_set[b]) mode[b] = 2'h0;
      if (susp_set[b] && mode[b] == 2'h0) mode[b] = 2'h1;
      if (!susp_set[b] && mode[b] == 2'h1) mode[b] = 2'h0;
    end
    pbusy = busy_set;
  end
endmodule : fbh_flash_model

// ==== tb/fbh_host_bench.sv ====
// bench: command stimulus for the flash host, checked against a mirror model
`timescale 1ns/100ps
module fbh_host_bench;
  import fbh_pkg::*;
  localparam logic [15:0] MAKER = 16'h00A1; // arbitrary value
  localparam logic [15:0] PART  = 16'h0B2C; // arbitrary value
  logic        sys_clk   = 1'b0;
  logic        rst       = 1'b1;
  logic        cmd_valid = 1'b0;
  fbh_op_t     cmd_op    = OP_READ;
  logic [21:0] cmd_addr  = 22'h000000;
  logic [3:0]  busy      = 4'h0;
  logic [3:0]  susp      = 4'h0;
  logic        to_flag   = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_err, cs_n, we_n, oe_n, f_dq_oe;
  logic [15:0] rsp_data, f_dq_out, f_dq_in;
  logic [21:0] f_addr;
  logic [7:0]  bank_modes;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  logic [31:0] seed         = 32'h716B;
  logic [1:0]  md [4]       = '{2'h0, 2'h0, 2'h0, 2'h0};
  logic        qm           = 1'b0;
  logic [7:0]  qa [11] = '{8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h57, 8'h58, 8'h59,
                           8'h5A, 8'h5B};
  logic [15:0] qv [11] = '{16'h0000, 16'h0000, 16'h0085, 16'h0095, 16'h0001, 16'h0001,
                           16'h0004, 16'h0017, 16'h0030, 16'h0030, 16'h0017};

  always #12.5 sys_clk = ~sys_clk;

  fbh_host dut (.SYS_CLK(sys_clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_ERR(rsp_err), .BANK_BUSY(busy), .BANK_SUSP(susp), .TIMEOUT_FLAG(to_flag),
    .BANK_MODES(bank_modes), .F_ADDR(f_addr), .F_DQ_IN(f_dq_in), .F_DQ_OUT(f_dq_out),
    .F_DQ_OE(f_dq_oe), .F_CS_N(cs_n), .F_WE_N(we_n), .F_OE_N(oe_n));

  fbh_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash (.addr(f_addr),
    .dq_out(f_dq_out), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .dq_in(f_dq_in),
    .busy_set(busy), .susp_set(susp));

  // ----------------------------------------
  // mirror model and checks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [15:0] exp_rd(input logic [21:0] a);
    for (int i = 0; i < 11; i++) if (qm && a[7:0] == qa[i]) return qv[i];
    if (qm) return 16'h0000;
    if (md[a[21:20]] == 2'h2) begin
      return (a[7:0] == 8'h00) ? MAKER : (a[7:0] == 8'h01) ? PART :
             (a[7:0] == 8'h02) ? {15'h0000, a[12]} : 16'h0000;
    end
    if (md[a[21:20]] == 2'h1 && a[19:12] == 8'h00) return 16'h0080;
    return a[15:0] ^ {2'h0, a[21:20], 12'h5A5};
  endfunction : exp_rd

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t data got %h exp %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_err(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t err got %h exp %h", $time, got, exp);
    end
  endtask : chk_err

  task automatic chk_modes(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t modes got %h exp %h", $time, got, exp);
    end
  endtask : chk_modes

  // data bus stays driven past the strobe's rise and is let go for reads
  always @(posedge we_n) if (!rst) #1 chk_err(f_dq_oe, 1'b1);
  always @(negedge oe_n) if (!rst) #1 chk_err(f_dq_oe, 1'b0);

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // request held until taken, then one idle cycle after the response
  task automatic op_chk(input fbh_op_t op, input logic [21:0] a);
    logic [15:0] ed;
    logic        ee;
    ed = (op == OP_READ) ? exp_rd(a) : 16'h0000;
    // a timeout flag marks every command except reset, which leaves the flag set
    ee = to_flag && op != OP_RESET;
    if (op == OP_RESET) begin
      qm = 1'b0;
      for (int b = 0; b < 4; b++) md[b] = {1'b0, susp[b]};
    end
    if (op == OP_AUTOSEL) begin
      ee = (|busy) || md[a[21:20]] == 2'h2;
      if (!ee) md[a[21:20]] = 2'h2;
      ee = ee || to_flag;
    end
    if (op == OP_QUERY) begin
      qm = 1'b1;
      for (int b = 0; b < 4; b++) md[b] = 2'h3;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    for (int n = 0; n < 500 && rsp_valid !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (rsp_valid !== 1'b1) num_errors++;
    chk_err(rsp_err, ee);
    if (op != OP_CHECK && !(op == OP_AUTOSEL && ee)) chk_data(rsp_data, ed);
    if (op != OP_READ && op != OP_CHECK) chk_modes(bank_modes, {md[3], md[2], md[1], md[0]});
    @(posedge sys_clk);
    #1;
  endtask : op_chk

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge sys_clk);
    #1 rst = 1'b0;
    @(posedge sys_clk);
    #1;
    chk_modes(bank_modes, 8'h00);
    repeat (6) op_chk(OP_READ, 22'(rnd()));
    op_chk(OP_QUERY, QUERY_ADDR);
    op_chk(OP_CHECK, 22'h000000);
    for (int i = 0; i < 11; i++) op_chk(OP_READ, {14'h0000, qa[i]});
    op_chk(OP_RESET, 22'(rnd()));
    for (int b = 0; b < 4; b++) begin
      op_chk(OP_AUTOSEL, {2'(b), 20'h00000});
      for (int k = 0; k < 3; k++) begin
        r = rnd();
        op_chk(OP_READ, {2'(b), r[19:8], 8'(k)});
      end
      op_chk(OP_READ, {2'(b) + 2'h1, r[19:0]});
      op_chk(OP_AUTOSEL, {2'(b), 20'h00000});
      op_chk(OP_RESET, 22'(rnd()));
    end
    susp = 4'h2;
    md[1] = 2'h1;
    settle();
    r = rnd();
    op_chk(OP_READ, {2'h1, 8'h00, r[11:0]});
    op_chk(OP_READ, {2'h1, 8'h3C, r[11:0]});
    op_chk(OP_AUTOSEL, 22'h100000);
    op_chk(OP_RESET, 22'(rnd()));
    op_chk(OP_READ, {2'h1, 8'h00, r[11:0]});
    busy = 4'h8;
    settle();
    op_chk(OP_AUTOSEL, 22'h000000);
    op_chk(OP_AUTOSEL, 22'h300000);
    op_chk(OP_READ, {2'h0, r[19:0]});
    busy = 4'h0;
    to_flag = 1'b1;
    settle();
    op_chk(OP_READ, 22'(rnd()));
    op_chk(OP_RESET, 22'(rnd()));
    to_flag = 1'b0;
    susp = 4'h0;
    md[1] = 2'h0;
    settle();
    op_chk(OP_RESET, 22'(rnd()));
    repeat (6) op_chk(OP_READ, 22'(rnd()));
    close_out();
  end
endmodule : fbh_host_bench
